/* core/xse_exec.sv */
// Extended stack instruction decode and execution unit.
`timescale 1ns/1ps
module xse_exec
    import xse_pkg::*;
(
    // Clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        resetn,
    // Configuration
    input  wire logic                        extended_set_enable,
    // Fetch and decode
    input  wire logic                        instr_valid,
    input  wire logic [xse_pkg::WORD_W-1:0]  instr_word,
    input  wire logic [xse_pkg::PC_W-1:0]    program_counter,
    input  wire logic [7:0]                  working_register,
    input  wire logic [7:0]                  pc_high_latch,
    input  wire logic [7:0]                  pc_upper_latch,
    output logic                             instr_claimed,
    output logic                             fetch_stall,
    // Program counter load
    output logic                             pc_load,
    output logic      [xse_pkg::PC_W-1:0]    pc_load_value,
    // Return stack
    input  wire logic [xse_pkg::PC_W-1:0]    return_stack_top,
    output logic                             rstack_push,
    output logic                             rstack_pop,
    output logic      [xse_pkg::PC_W-1:0]    rstack_push_value,
    // Pointer file
    input  wire logic [xse_pkg::DADDR_W-1:0] ptr0,
    input  wire logic [xse_pkg::DADDR_W-1:0] ptr1,
    input  wire logic [xse_pkg::DADDR_W-1:0] software_stack_pointer,
    output logic                             ptr_we,
    output logic      [1:0]                  ptr_sel,
    output logic      [xse_pkg::DADDR_W-1:0] ptr_wdata,
    // Data memory
    output logic                             dmem_re,
    output logic      [xse_pkg::DADDR_W-1:0] dmem_raddr,
    input  wire logic [7:0]                  dmem_rdata,
    output logic                             dmem_we,
    output logic      [xse_pkg::DADDR_W-1:0] dmem_waddr,
    output logic      [7:0]                  dmem_wdata
);
    import xse_pkg::*;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    function automatic logic is_indirect(input logic [DADDR_W-1:0] a);
        is_indirect = (a >= INDIR_LO) && (a <= INDIR_HI);
    endfunction

    xse_state_e               state_r;
    logic [DADDR_W-1:0]       mv_src_r;
    logic                     mv_abs_r;
    logic [DADDR_W-1:0]       alu_in;
    logic [DADDR_W-1:0]       alu_out;

    wire logic [7:0] oph     = instr_word[15:8];
    wire logic [1:0] fsel    = instr_word[7:6];
    wire logic       first   = instr_valid && extended_set_enable && (state_r == XSE_IDLE);
    wire logic       d_add   = first && (oph == OPH_PTR_ADD);
    wire logic       d_sub   = first && (oph == OPH_PTR_SUB);
    wire logic       d_ret   = (d_add || d_sub) && (fsel == SEL_SSP);
    wire logic       d_push  = first && (oph == OPH_PUSH_LIT);
    wire logic       d_call  = first && (instr_word == OP_CALL_W);
    wire logic       d_move  = first && (oph == OPH_MOVE_IDX);
    wire logic       second  = instr_valid && (state_r == XSE_MV_SRC);

    assign instr_claimed = d_add || d_sub || d_push || d_call || d_move || second;
    assign fetch_stall   = (state_r == XSE_MV_WR);

    // Pointer selection: the return form always acts on the stack pointer.
    always_comb
    begin
        case (fsel)
            2'h0:    alu_in = ptr0;
            2'h1:    alu_in = ptr1;
            default: alu_in = software_stack_pointer;
        endcase
    end

    xse_ptr_alu u_alu (
        .ptr_in  (alu_in),
        .lit     (instr_word[5:0]),
        .sub     (d_sub),
        .ptr_out (alu_out)
    );

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            state_r <= XSE_IDLE;
        else
        begin
            case (state_r)
                XSE_IDLE:
                begin
                    if (d_ret)
                        state_r <= XSE_RET_NOP;
                    else if (d_call)
                        state_r <= XSE_CALL_NOP;
                    else if (d_move)
                        state_r <= XSE_MV_SRC;
                    else
                        state_r <= XSE_IDLE;
                end
                XSE_RET_NOP:  state_r <= XSE_IDLE;
                XSE_CALL_NOP: state_r <= XSE_IDLE;
                XSE_MV_SRC:
                begin
                    if (instr_valid)
                        state_r <= XSE_MV_WR;
                    else
                        state_r <= XSE_MV_SRC;
                end
                XSE_MV_WR:    state_r <= XSE_IDLE;
                default:      state_r <= XSE_IDLE;
            endcase
        end
    end

    // Source address captured from the first word of an indexed move.
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            mv_src_r <= 12'h000;
            mv_abs_r <= 1'b0;
        end
        else if (d_move)
        begin
            mv_src_r <= software_stack_pointer + {5'h00, instr_word[6:0]};
            mv_abs_r <= ~instr_word[7];
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Pointer writes; no status flag is ever produced here.
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            ptr_we    <= 1'b0;
            ptr_sel   <= 2'h0;
            ptr_wdata <= 12'h000;
        end
        else
        begin
            ptr_we    <= d_add || d_sub || d_push;
            ptr_sel   <= (d_ret || d_push) ? SEL_PTR2 : fsel;
            ptr_wdata <= d_push ? (software_stack_pointer - PTR_ONE) : alu_out;
        end
    end

    // Return stack and PC load. W, status and bank select are never written.
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            pc_load           <= 1'b0;
            pc_load_value     <= 21'h000000;
            rstack_push       <= 1'b0;
            rstack_pop        <= 1'b0;
            rstack_push_value <= 21'h000000;
        end
        else
        begin
            pc_load     <= d_ret || d_call;
            rstack_pop  <= d_ret;
            rstack_push <= d_call;
            rstack_push_value <= program_counter + PC_STEP;
            if (d_call)
                pc_load_value <= {pc_upper_latch[4:0], pc_high_latch, working_register};
            else
                pc_load_value <= return_stack_top;
        end
    end

    // Data memory: source read while the second word is presented, destination write after second word.
    assign dmem_re    = (state_r == XSE_MV_SRC) && instr_valid;
    assign dmem_raddr = mv_src_r;

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            dmem_we    <= 1'b0;
            dmem_waddr <= 12'h000;
            dmem_wdata <= 8'h00;
        end
        else if (d_push)
        begin
            dmem_we    <= 1'b1;
            dmem_waddr <= software_stack_pointer;
            dmem_wdata <= instr_word[7:0];
        end
        else if (second && (instr_word[15:12] == OP_SECOND_HI))
        begin
            // Programs must not aim these at PC or return-stack registers.
            if (mv_abs_r)
            begin
                dmem_we    <= 1'b1;
                dmem_waddr <= instr_word[11:0];
            end
            else
            begin
                dmem_waddr <= software_stack_pointer + {5'h00, instr_word[6:0]};
                dmem_we    <= !is_indirect(software_stack_pointer
                                           + {5'h00, instr_word[6:0]});
            end
            dmem_wdata <= is_indirect(mv_src_r) ? BYTE_ZERO : dmem_rdata;
        end
        else
            dmem_we <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_ret_pops: assert property (@(posedge clk_sys) disable iff (!resetn)
        d_ret |=> rstack_pop && pc_load && state_r == XSE_RET_NOP)
        else $error("return form did not pop");
    chk_ret_two_cyc: assert property (@(posedge clk_sys) disable iff (!resetn)
        d_ret |=> ##1 state_r == XSE_IDLE)
        else $error("return form not two cycles");
    chk_call_push: assert property (@(posedge clk_sys) disable iff (!resetn)
        d_call |=> rstack_push && rstack_push_value == $past(program_counter) + PC_STEP)
        else $error("call push wrong");
    chk_call_pc: assert property (@(posedge clk_sys) disable iff (!resetn)
        d_call |=> pc_load_value[7:0] == $past(working_register))
        else $error("call target wrong");
    chk_disabled: assert property (@(posedge clk_sys) disable iff (!resetn)
        !extended_set_enable && state_r == XSE_IDLE |=> !ptr_we && !pc_load && !dmem_we)
        else $error("executed while disabled");
    chk_push_dec: assert property (@(posedge clk_sys) disable iff (!resetn)
        d_push |=> ptr_wdata == $past(software_stack_pointer) - PTR_ONE
                   && dmem_waddr == $past(software_stack_pointer))
        else $error("push literal wrong");
    chk_sub_ptr: assert property (@(posedge clk_sys) disable iff (!resetn)
        d_sub && fsel != SEL_SSP |=> ptr_we && ptr_wdata == $past(alu_in) - $past(instr_word[5:0]))
        else $error("pointer subtract wrong");
    chk_add_ptr: assert property (@(posedge clk_sys) disable iff (!resetn)
        d_add |=> ptr_we && ptr_wdata == $past(alu_in) + $past(instr_word[5:0]))
        else $error("pointer add wrong");
    chk_ind_nowrite: assert property (@(posedge clk_sys) disable iff (!resetn)
        second && !mv_abs_r && is_indirect(software_stack_pointer + {5'h00, instr_word[6:0]})
        |=> !dmem_we)
        else $error("indirect destination written");

    // ------------------------------------------------------------------
    // Return and call checks
    // ------------------------------------------------------------------
    chk_addret_ptr: assert property (@(posedge clk_sys) disable iff (!resetn)
        d_ret && d_add |=> ptr_we && ptr_wdata == $past(software_stack_pointer)
                           + $past(instr_word[5:0]))
        else $error("add-and-return pointer wrong");
    chk_subret_ptr: assert property (@(posedge clk_sys) disable iff (!resetn)
        d_ret && d_sub |=> ptr_we && rstack_pop && ptr_wdata == $past(software_stack_pointer)
                           - $past(instr_word[5:0]))
        else $error("subtract-and-return pointer wrong");
    chk_ret_sel: assert property (@(posedge clk_sys) disable iff (!resetn)
        d_ret |=> ptr_sel == SEL_PTR2 && pc_load_value == $past(return_stack_top))
        else $error("return form used wrong pointer");
    chk_ret_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_r == XSE_RET_NOP |=> !ptr_we && !pc_load && !rstack_pop && !rstack_push
                                   && !dmem_we)
        else $error("return second cycle not idle");
    chk_call_target: assert property (@(posedge clk_sys) disable iff (!resetn)
        d_call |=> pc_load && pc_load_value == {$past(pc_upper_latch[4:0]),
                                                $past(pc_high_latch), $past(working_register)})
        else $error("call target not built from latches");
    chk_call_keep: assert property (@(posedge clk_sys) disable iff (!resetn)
        d_call |=> !rstack_pop && !ptr_we && !dmem_we)
        else $error("call touched more than the return stack");
    chk_call_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_r == XSE_CALL_NOP |=> !ptr_we && !pc_load && !rstack_push && !rstack_pop
                                    && !dmem_we)
        else $error("call second cycle not idle");

    // ------------------------------------------------------------------
    // Move, push, pointer-subtract select and disabled-set checks
    // ------------------------------------------------------------------
    chk_move_src: assert property (@(posedge clk_sys) disable iff (!resetn)
        d_move |=> state_r == XSE_MV_SRC && dmem_raddr == $past(software_stack_pointer)
                                                         + $past(instr_word[6:0]))
        else $error("indexed source address wrong");
    chk_abs_dest: assert property (@(posedge clk_sys) disable iff (!resetn)
        second && mv_abs_r && instr_word[15:12] == OP_SECOND_HI
        |=> dmem_we && fetch_stall && dmem_waddr == $past(instr_word[11:0]))
        else $error("absolute destination wrong");
    chk_idx_dest: assert property (@(posedge clk_sys) disable iff (!resetn)
        second && !mv_abs_r && instr_word[15:12] == OP_SECOND_HI
        |=> dmem_waddr == $past(software_stack_pointer) + $past(instr_word[6:0]))
        else $error("indexed destination wrong");
    chk_src_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
        second && is_indirect(mv_src_r) && instr_word[15:12] == OP_SECOND_HI
        |=> dmem_wdata == BYTE_ZERO)
        else $error("indirect source not read as zero");
    // The copy check trusts the memory's answer, so a wrong read address shows in chk_move_src.
    chk_src_copy: assert property (@(posedge clk_sys) disable iff (!resetn)
        second && !is_indirect(mv_src_r) && instr_word[15:12] == OP_SECOND_HI
        |=> dmem_wdata == $past(dmem_rdata))
        else $error("source byte not copied");
    chk_move_len: assert property (@(posedge clk_sys) disable iff (!resetn)
        d_move ##1 second |=> fetch_stall ##1 state_r == XSE_IDLE)
        else $error("indexed move not two words and a stall");
    chk_push_data: assert property (@(posedge clk_sys) disable iff (!resetn)
        d_push |=> dmem_we && ptr_we && ptr_sel == SEL_PTR2
                   && dmem_wdata == $past(instr_word[7:0]))
        else $error("push literal data wrong");
    chk_sub_sel: assert property (@(posedge clk_sys) disable iff (!resetn)
        d_sub && fsel != SEL_SSP |=> ptr_sel == $past(fsel) && !pc_load && !rstack_pop)
        else $error("pointer subtract selected wrong pointer");
    chk_off_unclaimed: assert property (@(posedge clk_sys) disable iff (!resetn)
        !extended_set_enable && state_r == XSE_IDLE |-> !instr_claimed)
        else $error("word claimed while extended set disabled");

    cov_ret:  cover property (@(posedge clk_sys) d_ret);
    cov_call: cover property (@(posedge clk_sys) d_call);
    cov_move: cover property (@(posedge clk_sys) d_move ##1 second);
    cov_push: cover property (@(posedge clk_sys) d_push);
    cov_off:  cover property (@(posedge clk_sys) !extended_set_enable && instr_valid);
endmodule

/* core/xse_pkg.sv */
// Constants and types shared by the extended stack instruction executor.
package xse_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int DADDR_W = 12;
    localparam int PC_W    = 21;
    localparam int WORD_W  = 16;

    // ------------------------------------------------------------------
    // Opcode fields
    // ------------------------------------------------------------------
    localparam logic [7:0]  OPH_PTR_ADD  = 8'hE8;
    localparam logic [7:0]  OPH_PTR_SUB  = 8'hE9;
    localparam logic [7:0]  OPH_PUSH_LIT = 8'hFA;
    localparam logic [7:0]  OPH_MOVE_IDX = 8'hEB;
    localparam logic [15:0] OP_CALL_W    = 16'h0014;
    localparam logic [3:0]  OP_SECOND_HI = 4'hF;
    localparam logic [1:0]  SEL_SSP      = 2'h3;
    localparam logic [1:0]  SEL_PTR2     = 2'h2;
    localparam logic [PC_W-1:0] PC_STEP  = 21'h000002;
    localparam logic [DADDR_W-1:0] PTR_ONE = 12'h001;
    localparam logic [7:0]  BYTE_ZERO    = 8'h00;

    // Indirect-access register window (top of data space).
    localparam logic [DADDR_W-1:0] INDIR_LO = 12'hFDB;
    localparam logic [DADDR_W-1:0] INDIR_HI = 12'hFEF;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        XSE_IDLE    = 3'b000,
        XSE_RET_NOP = 3'b001,
        XSE_CALL_NOP= 3'b010,
        XSE_MV_SRC  = 3'b011,
        XSE_MV_WR   = 3'b100
    } xse_state_e;

endpackage

/* core/xse_ptr_alu.sv */
// Twelve-bit pointer adder and subtractor for literal pointer adjustment.
`timescale 1ns/1ps
module xse_ptr_alu
    import xse_pkg::*;
(
    // Operands
    input  wire logic [xse_pkg::DADDR_W-1:0] ptr_in,
    input  wire logic [5:0]                  lit,
    input  wire logic                        sub,
    // Result
    output logic      [xse_pkg::DADDR_W-1:0] ptr_out
);
    // Carry and borrow run through all twelve bits.
    always_comb
    begin
        if (sub)
            ptr_out = ptr_in - {6'h00, lit};
        else
            ptr_out = ptr_in + {6'h00, lit};
    end
endmodule

/* test/extended_stack_instruction_exec_tb_top.sv */
// Self-checking testbench for the extended stack instruction executor.
`timescale 1ns/1ps
module extended_stack_instruction_exec_tb_top;
    import xse_pkg::*;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    typedef struct {logic [15:0] w; logic [1:0] sel; logic [11:0] val;
                    logic ret; logic push;} xse_row_s;
    localparam logic [20:0] TOS_VAL = 21'h012345;
    logic clk_sys = 1'b0, resetn = 1'b0, extended_set_enable = 1'b1, instr_valid = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic [20:0] program_counter = 21'h000200;
    logic [7:0] working_register = 8'h06, pc_high_latch = 8'h10, pc_upper_latch = 8'hE3;
    logic [11:0] ptr0 = 12'h010, ptr1 = 12'hFFE, software_stack_pointer = 12'h3FF;
    logic instr_claimed, fetch_stall, pc_load, rstack_push, rstack_pop, ptr_we;
    logic dmem_re, dmem_we;
    logic [20:0] pc_load_value, rstack_push_value;
    logic [1:0] ptr_sel;
    logic [11:0] ptr_wdata, dmem_raddr, dmem_waddr;
    logic [7:0] dmem_rdata, dmem_wdata;
    int fail_count = 0;
    int check_count = 0;
    xse_row_s rows [8] = '{
        '{16'hE823, 2'h0, 12'h033, 1'b0, 1'b0},
        '{16'hE843, 2'h1, 12'h001, 1'b0, 1'b0},
        '{16'hE8A3, 2'h2, 12'h422, 1'b0, 1'b0},
        '{16'hE9A3, 2'h2, 12'h3DC, 1'b0, 1'b0},
        '{16'hE93F, 2'h0, 12'hFD1, 1'b0, 1'b0},
        '{16'hE8E3, 2'h2, 12'h422, 1'b1, 1'b0},
        '{16'hE9E3, 2'h2, 12'h3DC, 1'b1, 1'b0},
        '{16'hFA08, 2'h2, 12'h3FE, 1'b0, 1'b1}};

    xse_exec dut (.clk_sys(clk_sys), .resetn(resetn), .extended_set_enable(extended_set_enable),
        .instr_valid(instr_valid), .instr_word(instr_word), .program_counter(program_counter),
        .working_register(working_register), .pc_high_latch(pc_high_latch),
        .pc_upper_latch(pc_upper_latch), .instr_claimed(instr_claimed),
        .fetch_stall(fetch_stall), .pc_load(pc_load), .pc_load_value(pc_load_value),
        .return_stack_top(TOS_VAL), .rstack_push(rstack_push), .rstack_pop(rstack_pop),
        .rstack_push_value(rstack_push_value), .ptr0(ptr0), .ptr1(ptr1),
        .software_stack_pointer(software_stack_pointer), .ptr_we(ptr_we), .ptr_sel(ptr_sel),
        .ptr_wdata(ptr_wdata), .dmem_re(dmem_re), .dmem_raddr(dmem_raddr),
        .dmem_rdata(dmem_rdata), .dmem_we(dmem_we), .dmem_waddr(dmem_waddr),
        .dmem_wdata(dmem_wdata));

    xse_dmem_model model (.clk_sys(clk_sys), .dmem_re(dmem_re), .dmem_raddr(dmem_raddr),
        .dmem_rdata(dmem_rdata), .dmem_we(dmem_we), .dmem_waddr(dmem_waddr),
        .dmem_wdata(dmem_wdata));

    always #2 clk_sys = ~clk_sys;

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Called at a falling edge; returns at the next one, where the answer stands.
    task automatic drive(input logic [15:0] w);
        instr_valid = 1'b1;
        instr_word = w;
        @(negedge clk_sys);
    endtask

    task automatic idle();
        instr_valid = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask

    // Destinations never name the program counter or return-top registers.
    task automatic mv(input logic [15:0] w1, w2, input logic [11:0] src, dst,
                      input logic [7:0] data, input logic we);
        drive(w1);
        chk(dmem_re, 1'b1);
        chk(instr_claimed, 1'b1);
        chk(dmem_raddr, src);
        drive(w2);
        chk(fetch_stall, 1'b1);
        chk(dmem_we, we);
        if (we)
        begin
            chk(dmem_waddr, dst);
            chk(dmem_wdata, data);
        end
        idle();
        if (we)
            chk(model.mem[dst], data);
    endtask

    // ------------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------------
    initial
    begin
        repeat (8) @(negedge clk_sys);
        resetn = 1'b1;
        @(negedge clk_sys);
        foreach (rows[i])
        begin
            drive(rows[i].w);
            chk(ptr_we, 1'b1);
            chk(ptr_sel, rows[i].sel);
            chk(ptr_wdata, rows[i].val);
            chk(rstack_pop, rows[i].ret);
            chk(pc_load, rows[i].ret);
            if (rows[i].ret)
                chk(pc_load_value, TOS_VAL);
            chk(dmem_we, rows[i].push);
            if (rows[i].push)
            begin
                chk(dmem_waddr, 12'h3FF);
                chk(dmem_wdata, 8'h08);
            end
            if (rows[i].ret)
            begin
                drive(16'hFA55);
                chk(ptr_we | dmem_we, 1'b0);
            end
            idle();
        end
        // Computed call: the upper latch carries spare high bits that must be dropped.
        drive(16'h0014);
        chk(rstack_push, 1'b1);
        chk(rstack_push_value, 21'h000202);
        chk(pc_load_value, 21'h031006);
        chk(rstack_pop, 1'b0);
        drive(16'hFA55);
        chk(ptr_we | dmem_we | pc_load | rstack_push, 1'b0);
        idle();
        // Indexed moves, including both indirect-window corner cases.
        software_stack_pointer = 12'h080;
        model.mem[12'h085] = 8'h33;
        model.mem[12'hFFF] = 8'h5A;
        model.mem[12'hFDB] = 8'h77;
        mv(16'hEB05, 16'hF123, 12'h085, 12'h123, 8'h33, 1'b1);
        mv(16'hEB85, 16'hFF86, 12'h085, 12'h086, 8'h33, 1'b1);
        software_stack_pointer = 12'hF80;
        mv(16'hEB7F, 16'hF000, 12'hFFF, 12'h000, 8'h5A, 1'b1);
        software_stack_pointer = 12'hFD0;
        mv(16'hEB0B, 16'hF200, 12'hFDB, 12'h200, 8'h00, 1'b1);
        mv(16'hEB81, 16'hF010, 12'hFD1, 12'hFE0, 8'h00, 1'b0);
        // Extended set disabled: nothing is claimed or executed.
        extended_set_enable = 1'b0;
        drive(16'hE8A3);
        chk(instr_claimed | ptr_we, 1'b0);
        idle();
        extended_set_enable = 1'b1;
        // A reset landing with a push must swallow the push.
        instr_valid = 1'b1;
        instr_word = 16'hFA11;
        resetn = 1'b0;
        @(negedge clk_sys);
        chk(dmem_we | ptr_we, 1'b0);
        resetn = 1'b1;
        idle();
        // A reset in mid-move must drop the move, so an F-word after it is a push again.
        drive(16'hEB05);
        instr_word = 16'hF123;
        resetn = 1'b0;
        @(negedge clk_sys);
        chk(dmem_we | ptr_we | fetch_stall, 1'b0);
        resetn = 1'b1;
        drive(16'hFA11);
        chk(ptr_we & dmem_we, 1'b1);
        chk(dmem_waddr, 12'hFD0);
        chk(dmem_wdata, 8'h11);
        idle();
        complete_run();
    end

    initial
    begin
        repeat (2000) @(posedge clk_sys);
        fail_count++;
        complete_run();
    end
endmodule

/* test/xse_dmem_model.sv */
// Data memory model that stands on the far side of the executor.
`timescale 1ns/1ps
module xse_dmem_model
    import xse_pkg::*;
(
    // Clock
    input  wire logic                        clk_sys,
    // Read side
    input  wire logic                        dmem_re,
    input  wire logic [xse_pkg::DADDR_W-1:0] dmem_raddr,
    output logic      [7:0]                  dmem_rdata,
    // Write side
    input  wire logic                        dmem_we,
    input  wire logic [xse_pkg::DADDR_W-1:0] dmem_waddr,
    input  wire logic [7:0]                  dmem_wdata
);
    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [7:0] mem [4096];
    logic [7:0] last_r = 8'hA5;

    // An idle read port shows the inverse of the last byte, so a stale read cannot pass.
    always_comb dmem_rdata = dmem_re ? mem[dmem_raddr] : ~last_r;

    always @(posedge clk_sys)
    begin
        if (dmem_re)
            last_r <= mem[dmem_raddr];
        if (dmem_we)
            mem[dmem_waddr] <= dmem_wdata;
    end
endmodule
